// [tam_map.svh]
// Register map and reset values for the thermal alarm status block.
// Function
// - Enabled channel below low limit sets low flag
// - Low flags read-only, reset zero, bits 7:4 reserved
// - Masked channel never drives the alert output
// - Four host-writable mask bits, reset zero
// - Sequencer skips every disabled channel
// - Disabled remote channel gets no diode check
// - All four channel enables set after reset
// - Diode fault flags bits 3:1, bit 0 zero
// - Above own high limit sets high flag
// - One shared low limit, upper byte resets C9h
`ifndef TAM_MAP_SVH
`define TAM_MAP_SVH

`define TAM_ADDR_LOW_LIM_MSB 8'h30
`define TAM_ADDR_LOW_LIM_LSB 8'h31
`define TAM_ADDR_HIGH_STAT   8'h32
`define TAM_ADDR_LOW_STAT    8'h33
`define TAM_ADDR_ALERT_MASK  8'h34
`define TAM_ADDR_CHAN_EN     8'h35
`define TAM_ADDR_DIODE_FLT   8'h36

`define TAM_RST_LOW_LIM_MSB  8'hC9
`define TAM_RST_LOW_LIM_LSB  8'h00
`define TAM_RST_STAT         4'h0
`define TAM_RST_MASK         4'h0
`define TAM_RST_CHAN_EN      4'hF
`define TAM_RST_DIODE_FLT    3'h0

`define TAM_NCHAN            4
`define TAM_CHAN_LOCAL       2'h0
`define TAM_CHAN_LAST        2'h3
`define TAM_UNMAPPED_DATA    8'h00

`endif

// [tam_pkg.sv]
// Types shared by the thermal alarm status block.
package tam_pkg;

  typedef logic [1:0]  tam_chan_t;
  typedef logic [3:0]  tam_flags_t;
  typedef logic [15:0] tam_temp_t;

  typedef enum logic [2:0] {
    TAM_SEQ_PICK  = 3'b001,
    TAM_SEQ_START = 3'b010,
    TAM_SEQ_WAIT  = 3'b100
  } tam_seq_e;

endpackage

// [tam_link_xfer.sv]
// Toggle handshake that carries register requests from the link clock.
`timescale 1ns/1ps
module tam_link_xfer
  import tam_pkg::*;
(
  // Link domain.
  input  wire logic       clk_link,
  input  wire logic       link_rst,
  input  wire logic       link_req,
  input  wire logic       link_wr,
  input  wire logic [7:0] link_addr,
  input  wire logic [7:0] link_wdata,
  output logic            link_busy,
  output logic            link_done,
  output logic [7:0]      link_rdata,
  // System domain.
  input  wire logic       clk_sys,
  input  wire logic       srst,
  output logic            sys_req,
  output logic            sys_wr,
  output logic [7:0]      sys_addr,
  output logic [7:0]      sys_wdata,
  input  wire logic [7:0] sys_rdata
);

  logic       req_tgl_q;
  logic       ack_s1_q;
  logic       ack_s2_q;
  logic       ack_s3_q;
  logic       busy_q;
  logic       done_q;
  logic       wr_q;
  logic [7:0] addr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic       req_s1_q;
  logic       req_s2_q;
  logic       req_s3_q;
  logic       ack_tgl_q;
  logic [7:0] sys_rdata_q;

  // Request fields stay frozen while busy, so the system side sees them
  // stable once the toggle has passed its synchroniser.
  always_ff @(posedge clk_link) begin
    if (link_rst) begin
      req_tgl_q <= 1'b0;
      busy_q    <= 1'b0;
      wr_q      <= 1'b0;
      addr_q    <= 8'h00;
      wdata_q   <= 8'h00;
    end else if (link_req && !busy_q) begin
      req_tgl_q <= ~req_tgl_q;
      busy_q    <= 1'b1;
      wr_q      <= link_wr;
      addr_q    <= link_addr;
      wdata_q   <= link_wdata;
    end else if (ack_s3_q != ack_s2_q) begin
      busy_q    <= 1'b0;
    end
  end

  always_ff @(posedge clk_link) begin
    if (link_rst) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
      ack_s3_q <= 1'b0;
      done_q   <= 1'b0;
      rdata_q  <= 8'h00;
    end else begin
      ack_s1_q <= ack_tgl_q;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
      done_q   <= ack_s3_q != ack_s2_q;
      if (ack_s3_q != ack_s2_q) begin
        rdata_q <= sys_rdata_q;
      end
    end
  end

  assign link_busy  = busy_q;
  assign link_done  = done_q;
  assign link_rdata = rdata_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      req_s1_q    <= 1'b0;
      req_s2_q    <= 1'b0;
      req_s3_q    <= 1'b0;
      ack_tgl_q   <= 1'b0;
      sys_rdata_q <= 8'h00;
    end else begin
      req_s1_q <= req_tgl_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      if (sys_req) begin
        ack_tgl_q   <= ~ack_tgl_q;
        sys_rdata_q <= sys_rdata;
      end
    end
  end

  assign sys_req   = req_s3_q != req_s2_q;
  assign sys_wr    = wr_q;
  assign sys_addr  = addr_q;
  assign sys_wdata = wdata_q;

endmodule

// [tam_thermal_alarm.sv]
// Status, mask, enable and diode fault registers with conversion sequencer.
`timescale 1ns/1ps
`include "tam_map.svh"
module tam_thermal_alarm
  import tam_pkg::*;
(
  // System clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // Register port from the serial engine, on the link clock.
  input  wire logic        clk_link,
  input  wire logic        link_rst,
  input  wire logic        reg_req,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic             reg_busy,
  output logic             reg_done,
  output logic [7:0]       reg_rdata,
  // Conversion engine.
  output logic             conv_start,
  output logic [1:0]       conv_chan,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_temp,
  input  wire logic        conv_diode_fault,
  // High limits, one per channel, held outside this block.
  input  wire logic [15:0] high_limit_local,
  input  wire logic [15:0] high_limit_rem1,
  input  wire logic [15:0] high_limit_rem2,
  input  wire logic [15:0] high_limit_rem3,
  // Open-drain alert pin, low when active.
  output logic             over_temp_alert_output_out,
  output logic             over_temp_alert_output_oe
);

  tam_seq_e   seq_q;
  tam_chan_t  chan_q;
  logic       start_q;
  logic [7:0] low_lim_msb_q;
  logic [7:0] low_lim_lsb_q;
  tam_flags_t high_stat_q;
  tam_flags_t low_stat_q;
  tam_flags_t mask_q;
  tam_flags_t chan_en_q;
  logic [2:0] diode_flt_q;
  logic       alert_q;
  logic       sys_req;
  logic       sys_wr;
  logic [7:0] sys_addr;
  logic [7:0] sys_wdata;
  logic [7:0] sys_rdata;
  logic       wr_evt;
  tam_temp_t  low_limit;
  tam_temp_t  high_limit;
  logic       chan_dis;

  tam_link_xfer u_xfer (
    .clk_link   (clk_link),
    .link_rst   (link_rst),
    .link_req   (reg_req),
    .link_wr    (reg_wr),
    .link_addr  (reg_addr),
    .link_wdata (reg_wdata),
    .link_busy  (reg_busy),
    .link_done  (reg_done),
    .link_rdata (reg_rdata),
    .clk_sys    (clk_sys),
    .srst       (srst),
    .sys_req    (sys_req),
    .sys_wr     (sys_wr),
    .sys_addr   (sys_addr),
    .sys_wdata  (sys_wdata),
    .sys_rdata  (sys_rdata)
  );

  // Next enabled channel after cur, wrapping; returns cur if none other.
  function automatic tam_chan_t next_chan(tam_chan_t cur, tam_flags_t en);
    tam_chan_t c;
    tam_chan_t r;
    c = cur;
    r = cur;
    for (int i = 0; i < `TAM_NCHAN; i++) begin
      c = tam_chan_t'(c + 2'h1);
      if (en[c] && r == cur) begin
        r = c;
      end
    end
    return r;
  endfunction

  // True when a write hits the given address.
  function automatic logic wr_hit(logic [7:0] a);
    return wr_evt && sys_addr == a;
  endfunction

  assign wr_evt     = sys_req && sys_wr;
  assign low_limit  = {low_lim_msb_q, low_lim_lsb_q};
  assign conv_start = start_q;
  assign conv_chan  = chan_q;
  assign chan_dis   = !chan_en_q[chan_q];

  always_comb begin
    unique case (chan_q)
      2'h0: high_limit = high_limit_local;
      2'h1: high_limit = high_limit_rem1;
      2'h2: high_limit = high_limit_rem2;
      2'h3: high_limit = high_limit_rem3;
    endcase
  end

  // Conversion sequencer.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      seq_q   <= TAM_SEQ_PICK;
      chan_q  <= `TAM_CHAN_LAST;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      unique case (seq_q)
        TAM_SEQ_PICK: begin
          if (chan_en_q != 4'h0) begin
            chan_q <= next_chan(chan_q, chan_en_q);
            seq_q  <= TAM_SEQ_START;
          end
        end
        TAM_SEQ_START: begin
          if (chan_dis) begin
            seq_q <= TAM_SEQ_PICK;
          end else begin
            start_q <= 1'b1;
            seq_q   <= TAM_SEQ_WAIT;
          end
        end
        TAM_SEQ_WAIT: begin
          if (conv_done) begin
            seq_q <= TAM_SEQ_PICK;
          end
        end
      endcase
    end
  end

  // Comparison flags follow each finished conversion of an enabled channel.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      high_stat_q <= `TAM_RST_STAT;
      low_stat_q  <= `TAM_RST_STAT;
    end else if (seq_q == TAM_SEQ_WAIT && conv_done && !chan_dis) begin
      high_stat_q[chan_q] <=
        $signed(conv_temp) > $signed(high_limit);
      low_stat_q[chan_q] <=
        $signed(conv_temp) < $signed(low_limit);
    end
  end

  // Host-written registers.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      low_lim_msb_q <= `TAM_RST_LOW_LIM_MSB;
      low_lim_lsb_q <= `TAM_RST_LOW_LIM_LSB;
      mask_q        <= `TAM_RST_MASK;
      chan_en_q     <= `TAM_RST_CHAN_EN;
    end else begin
      if (wr_hit(`TAM_ADDR_LOW_LIM_MSB)) begin
        low_lim_msb_q <= sys_wdata;
      end
      if (wr_hit(`TAM_ADDR_LOW_LIM_LSB)) begin
        low_lim_lsb_q <= sys_wdata;
      end
      if (wr_hit(`TAM_ADDR_ALERT_MASK)) begin
        mask_q <= sys_wdata[3:0];
      end
      if (wr_hit(`TAM_ADDR_CHAN_EN)) begin
        chan_en_q <= sys_wdata[3:0];
      end
    end
  end

  // Diode faults: host write loads bits 3:1, a detection in the same
  // cycle still sets its bit.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      diode_flt_q <= `TAM_RST_DIODE_FLT;
    end else begin
      logic [2:0] f;
      f = diode_flt_q;
      if (wr_hit(`TAM_ADDR_DIODE_FLT)) begin
        f = sys_wdata[3:1];
      end
      if (seq_q == TAM_SEQ_WAIT && conv_done && !chan_dis &&
          chan_q != `TAM_CHAN_LOCAL && conv_diode_fault) begin
        f[chan_q - 2'h1] = 1'b1;
      end
      diode_flt_q <= f;
    end
  end

  // Read data; reserved bits and unmapped addresses read zero.
  always_comb begin
    unique case (sys_addr)
      `TAM_ADDR_LOW_LIM_MSB: sys_rdata = low_lim_msb_q;
      `TAM_ADDR_LOW_LIM_LSB: sys_rdata = low_lim_lsb_q;
      `TAM_ADDR_HIGH_STAT:   sys_rdata = {4'h0, high_stat_q};
      `TAM_ADDR_LOW_STAT:    sys_rdata = {4'h0, low_stat_q};
      `TAM_ADDR_ALERT_MASK:  sys_rdata = {4'h0, mask_q};
      `TAM_ADDR_CHAN_EN:     sys_rdata = {4'h0, chan_en_q};
      `TAM_ADDR_DIODE_FLT:   sys_rdata = {4'h0, diode_flt_q, 1'b0};
      default:               sys_rdata = `TAM_UNMAPPED_DATA;
    endcase
  end

  // Alert pin pulls low while any unmasked flag is set.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= |((high_stat_q | low_stat_q) & ~mask_q);
    end
  end

  assign over_temp_alert_output_out = 1'b0;
  assign over_temp_alert_output_oe  = alert_q;

endmodule

// [tam_conv_model.sv]
// Behavioural converter answering the block's conversion requests.
`timescale 1ns/1ps
module tam_conv_model (
  // Clock and requests.
  input  wire logic        clk_sys,
  input  wire logic        srst,
  input  wire logic        conv_start,
  input  wire logic [1:0]  conv_chan,
  // Scenario settings.
  input  wire logic [63:0] temps,
  input  wire logic [3:0]  flt,
  input  wire logic [3:0]  dly,
  // Results.
  output logic             conv_done,
  output logic [15:0]      conv_temp,
  output logic             conv_diode_fault
);
  logic       run_q;
  logic [3:0] cnt_q;
  always_ff @(posedge clk_sys) begin
    conv_done <= 1'b0;
    if (srst) begin
      run_q <= 1'b0;
      conv_temp <= 16'h0000;
      conv_diode_fault <= 1'b0;
    end else if (conv_start) begin
      run_q <= 1'b1;
      cnt_q <= dly;
    end else if (run_q && cnt_q == 4'h0) begin
      run_q <= 1'b0;
      conv_done <= 1'b1;
      conv_temp <= temps[conv_chan*16 +: 16];
      conv_diode_fault <= flt[conv_chan];
    end else if (run_q) begin
      cnt_q <= cnt_q - 4'h1;
    end else begin
      // Results are meaningless outside the done pulse, so they toggle while no conversion runs.
      conv_temp <= ~conv_temp;
      conv_diode_fault <= ~conv_diode_fault;
    end
  end
endmodule

// [tam_thermal_alarm_props.sv]
// Concurrent checks on the thermal alarm block ports.
`timescale 1ns/1ps
module tam_thermal_alarm_props (
  // Clocks and resets.
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       clk_link,
  input  wire logic       link_rst,
  // Register port.
  input  wire logic       reg_req,
  input  wire logic       reg_busy,
  input  wire logic       reg_done,
  input  wire logic [7:0] reg_rdata,
  // Converter and alert pin.
  input  wire logic       conv_start,
  input  wire logic [1:0] conv_chan,
  input  wire logic       conv_done,
  input  wire logic       over_temp_alert_output_out,
  input  wire logic       over_temp_alert_output_oe
);
  logic wait_q;
  always_ff @(posedge clk_sys) begin
    if (srst || conv_done)
      wait_q <= 1'b0;
    else if (conv_start)
      wait_q <= 1'b1;
  end
  sequence s_accept;
    reg_req && !reg_busy;
  endsequence
  sequence s_answer;
    ##[1:12] reg_done;
  endsequence
  property p_busy;
    @(posedge clk_link) disable iff (link_rst) s_accept |=> reg_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy missing");
  property p_answer;
    @(posedge clk_link) disable iff (link_rst) s_accept |-> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("no done");
  property p_done;
    @(posedge clk_link) disable iff (link_rst)
      reg_done |-> !reg_busy ##1 !reg_done;
  endproperty
  a_done: assert property (p_done) else $error("bad done");
  property p_rdata;
    @(posedge clk_link) disable iff (link_rst)
      !reg_done |-> $stable(reg_rdata);
  endproperty
  a_rdata: assert property (p_rdata) else $error("rdata moved");
  property p_rst;
    @(posedge clk_sys) disable iff (srst) $fell(srst) |->
      !conv_start && conv_chan == 2'h3 && !over_temp_alert_output_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_hold;
    @(posedge clk_sys) disable iff (srst)
      conv_start || (wait_q && !conv_done) |=> $stable(conv_chan);
  endproperty
  a_hold: assert property (p_hold) else $error("chan moved");
  property p_one;
    @(posedge clk_sys) disable iff (srst) wait_q |-> !conv_start;
  endproperty
  a_one: assert property (p_one) else $error("start in wait");
  property p_od;
    @(posedge clk_sys) disable iff (srst) over_temp_alert_output_out == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("pin driven high");
endmodule
bind tam_thermal_alarm tam_thermal_alarm_props chk_u (
  .clk_sys(clk_sys), .srst(srst), .clk_link(clk_link), .link_rst(link_rst),
  .reg_req(reg_req), .reg_busy(reg_busy), .reg_done(reg_done),
  .reg_rdata(reg_rdata), .conv_start(conv_start), .conv_chan(conv_chan),
  .conv_done(conv_done),
  .over_temp_alert_output_out(over_temp_alert_output_out),
  .over_temp_alert_output_oe(over_temp_alert_output_oe));

// [tam_thermal_alarm_bench.sv]
// Self-checking bench for the thermal alarm block.
`timescale 1ns/1ps
module tam_thermal_alarm_bench;
  logic        clk_sys, srst, clk_link, link_rst, req, wr, busy, done;
  logic        cst, cdn, cfl, oe, oout;
  logic [7:0]  addr, wd, rd;
  logic [1:0]  cch;
  logic [15:0] ctemp;
  logic [15:0] hl [4];
  logic [63:0] temps;
  logic [3:0]  flt, dly, seen;
  int          n_mismatch = 0;
  int          checked = 0;
  int          cyc = 0;
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #3.7;
    forever #80 clk_link = ~clk_link;
  end
  tam_thermal_alarm dut_u (
    .clk_sys(clk_sys), .srst(srst), .clk_link(clk_link), .link_rst(link_rst),
    .reg_req(req), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wd),
    .reg_busy(busy), .reg_done(done), .reg_rdata(rd),
    .conv_start(cst), .conv_chan(cch), .conv_done(cdn),
    .conv_temp(ctemp), .conv_diode_fault(cfl),
    .high_limit_local(hl[0]), .high_limit_rem1(hl[1]),
    .high_limit_rem2(hl[2]), .high_limit_rem3(hl[3]),
    .over_temp_alert_output_out(oout), .over_temp_alert_output_oe(oe));
  tam_conv_model conv_u (
    .clk_sys(clk_sys), .srst(srst), .conv_start(cst), .conv_chan(cch),
    .temps(temps), .flt(flt), .dly(dly), .conv_done(cdn),
    .conv_temp(ctemp), .conv_diode_fault(cfl));
  always @(posedge clk_sys) begin
    if (cst === 1'b1)
      seen[cch] <= 1'b1;
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One register access; address and data stay put until done.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k = 0;
    @(posedge clk_link) #1;
    {req, wr, addr, wd} = {1'b1, w, a, d};
    @(posedge clk_link) #1;
    req = 1'b0;
    while (done !== 1'b1 && k < 14) begin
      @(posedge clk_link) #1;
      k++;
    end
    cmp({7'h00, done}, 8'h01);
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    cmp(rd, exp);
  endtask
  task automatic settle();
    repeat (150) @(posedge clk_sys);
    #1;
  endtask
  initial begin
    {srst, link_rst, req, wr, addr, wd} = {2'b11, 18'h00000};
    temps = {4{16'h1900}};
    hl = '{4{16'h7F00}};
    {flt, dly, seen} = 12'h000;
    repeat (6) @(posedge clk_link) #1;
    link_rst = 1'b0;
    @(posedge clk_sys) #1;
    srst = 1'b0;
    settle();
    cmp({4'h0, seen}, 8'h0F);
    chk(8'h33, 8'h00);
    chk(8'h34, 8'h00);
    chk(8'h35, 8'h0F);
    chk(8'h36, 8'h00);
    chk(8'h30, 8'hC9);
    chk(8'h7E, 8'h00);
    acc(1'b1, 8'h33, 8'hFF);
    chk(8'h33, 8'h00);
    acc(1'b1, 8'h34, 8'hFF);
    chk(8'h34, 8'h0F);
    acc(1'b1, 8'h34, 8'h00);
    temps = {16'h1900, 16'hC000, 16'h1900, 16'h7F10};
    dly = 4'h9;
    settle();
    chk(8'h33, 8'h04);
    chk(8'h32, 8'h01);
    cmp({7'h00, oe}, 8'h01);
    acc(1'b1, 8'h34, 8'h05);
    settle();
    cmp({7'h00, oe}, 8'h00);
    acc(1'b1, 8'h30, 8'hB0);
    temps = {16'hB000, 16'hC000, 16'hAFF0, 16'h7F10};
    settle();
    chk(8'h33, 8'h02);
    acc(1'b1, 8'h35, 8'h0C);
    settle();
    flt = 4'hB;
    seen = 4'h0;
    settle();
    cmp({4'h0, seen}, 8'h0C);
    chk(8'h36, 8'h08);
    flt = 4'h0;
    acc(1'b1, 8'h36, 8'h00);
    settle();
    chk(8'h36, 8'h00);
    chk(8'h31, 8'h00);
    report_and_stop();
  end
endmodule
